// ===== hdl/pdf_glue.sv
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps
module pdf_glue (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // PCI configuration access, one address phase per pulse
    input  wire logic        cfg_addr_phase,
    input  wire logic [3:0]  cfg_cmd,
    input  wire logic [5:0]  cfg_dword,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic        config_select_scsi,
    input  wire logic        config_select_net,
    output logic             cfg_claim_scsi,
    output logic             cfg_claim_net,
    output logic      [31:0] cfg_rdata,
    // Arbitration and parking
    input  wire logic        pci_bus_idle,
    input  wire logic        bus_grant_scsi,
    input  wire logic        bus_grant_net,
    input  wire logic        net_master_need,
    output logic             bus_request_scsi,
    output logic             bus_request_net,
    output logic             scsi_bus_owned,
    output logic             net_bus_owned,
    output logic      [31:0] pci_ad_o,
    output logic             pci_ad_oe,
    output logic      [3:0]  pci_cbe_o,
    output logic             pci_cbe_oe,
    output logic             pci_par_o,
    output logic             pci_par_oe,
    // Master engine events
    input  wire logic        target_abort_scsi,
    input  wire logic        master_abort_scsi,
    input  wire logic        target_abort_net,
    input  wire logic        master_abort_net,
    input  wire logic        dma_xfer_done,
    input  wire logic        dma_flush_done,
    input  wire logic        scsi_core_event,
    input  wire logic        net_core_event,
    // DMA engine control
    output logic             dma_running,
    output logic             dma_flush_command,
    // Interrupts
    output logic             irq_out_scsi,
    output logic             irq_out_net
);

    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdata;
        pdf_pkg::pdf_dma_st_t dma_st;
        logic [1:0]           dma_command_field;
        logic                 dma_abort;
        logic                 dma_done;
        logic [2:0]           irq_st;
        logic [2:0]           irq_mask;
        logic                 received_target_abort_flag_scsi;
        logic                 received_master_abort_flag_scsi;
        logic                 received_target_abort_flag_net;
        logic                 received_master_abort_flag_net;
        logic [7:0]           intpin_net;
        logic                 claim_scsi;
        logic                 claim_net;
        logic [31:0]          cfg_rdata;
        logic                 park;
        logic                 req_net;
    } pdf_state_t;

    pdf_state_t s_q;
    pdf_state_t s_d;

    // W1C clear mask for the low byte of a write, gated by its lane
    function automatic logic [7:0] pdf_w1c(input logic [3:0] be, input logic [31:0] wd);
        pdf_w1c = be[0] ? wd[7:0] : 8'h00;
    endfunction : pdf_w1c

    // Config status dword for one function
    function automatic logic [31:0] pdf_cfg_status(input logic rta, input logic rma);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[pdf_pkg::CFG_RTA_BIT] = rta;
        v[pdf_pkg::CFG_RMA_BIT] = rma;
        pdf_cfg_status = v;
    endfunction : pdf_cfg_status

    logic        acc;
    logic        wr_hit;
    logic [7:0]  clr;
    logic        cfg_is_cfg;
    logic        sel_scsi;
    logic        sel_net;
    logic        cfg_wr;
    logic [7:0]  dma_status_rd;

    // ==========================================================
    // Next-state logic
    always_comb begin
        s_d = s_q;
        acc = (avs_read | avs_write) & ~s_q.ack;
        wr_hit = avs_write & ~s_q.ack;
        clr = pdf_w1c(avs_byteenable, avs_writedata);
        s_d.ack = acc;
        dma_status_rd = 8'h00;
        dma_status_rd[pdf_pkg::DST_RUN_BIT] = s_q.dma_st == pdf_pkg::PDF_ST_RUN;
        dma_status_rd[pdf_pkg::DST_FLUSH_BIT] = s_q.dma_st == pdf_pkg::PDF_ST_FLUSH;
        dma_status_rd[pdf_pkg::DST_ABORT_BIT] = s_q.dma_abort;
        dma_status_rd[pdf_pkg::DST_DONE_BIT] = s_q.dma_done;

        // Register reads; unmapped offsets read zero, writes there are dropped
        if (acc) begin
            case (avs_address)
                pdf_pkg::OFS_DMA_CMD:    s_d.rdata = {30'h0, s_q.dma_command_field};
                pdf_pkg::OFS_DMA_STATUS: s_d.rdata = {24'h0, dma_status_rd};
                pdf_pkg::OFS_IRQ_STATUS: s_d.rdata = {29'h0, s_q.irq_st};
                pdf_pkg::OFS_IRQ_MASK:   s_d.rdata = {29'h0, s_q.irq_mask};
                default:                 s_d.rdata = 32'h0000_0000;
            endcase
        end

        // Sticky flags: clear by writing one, a same-cycle event wins
        if (wr_hit && avs_address == pdf_pkg::OFS_DMA_STATUS) begin
            if (clr[pdf_pkg::DST_ABORT_BIT]) s_d.dma_abort = 1'b0;
            if (clr[pdf_pkg::DST_DONE_BIT]) s_d.dma_done = 1'b0;
        end
        if (wr_hit && avs_address == pdf_pkg::OFS_IRQ_STATUS) begin
            s_d.irq_st = s_q.irq_st & ~clr[2:0];
        end
        if (wr_hit && avs_address == pdf_pkg::OFS_IRQ_MASK && avs_byteenable[0]) begin
            s_d.irq_mask = avs_writedata[2:0];
        end

        // DMA command decode
        if (wr_hit && avs_address == pdf_pkg::OFS_DMA_CMD && avs_byteenable[0]) begin
            s_d.dma_command_field = avs_writedata[1:0];
            case (pdf_pkg::pdf_dma_cmd_t'(avs_writedata[1:0]))
                pdf_pkg::PDF_CMD_IDLE: begin
                    s_d.dma_st = pdf_pkg::PDF_ST_IDLE;
                end
                pdf_pkg::PDF_CMD_FLUSH: begin
                    if (s_q.dma_st == pdf_pkg::PDF_ST_RUN) begin
                        s_d.dma_st = pdf_pkg::PDF_ST_FLUSH;
                    end
                end
                pdf_pkg::PDF_CMD_START: begin
                    s_d.dma_st = pdf_pkg::PDF_ST_RUN;
                end
                pdf_pkg::PDF_CMD_ABORT: begin
                    s_d.dma_st = pdf_pkg::PDF_ST_IDLE;
                    s_d.dma_abort = 1'b1;
                end
                default: begin
                    s_d.dma_st = pdf_pkg::PDF_ST_IDLE;
                end
            endcase
        end else begin
            case (s_q.dma_st)
                pdf_pkg::PDF_ST_IDLE: begin
                    s_d.dma_st = pdf_pkg::PDF_ST_IDLE;
                end
                pdf_pkg::PDF_ST_RUN: begin
                    if (dma_xfer_done) begin
                        s_d.dma_st = pdf_pkg::PDF_ST_IDLE;
                    end
                end
                pdf_pkg::PDF_ST_FLUSH: begin
                    if (dma_flush_done) begin
                        s_d.dma_st = pdf_pkg::PDF_ST_IDLE;
                    end
                end
                default: begin
                    s_d.dma_st = pdf_pkg::PDF_ST_IDLE;
                end
            endcase
        end

        // Aborts stop the SCSI transfer and never touch the interrupt status
        if (s_q.dma_st != pdf_pkg::PDF_ST_IDLE) begin
            if (target_abort_scsi || master_abort_scsi) begin
                s_d.dma_st = pdf_pkg::PDF_ST_IDLE;
            end
        end
        if (target_abort_scsi) s_d.dma_abort = 1'b1;
        if (master_abort_scsi) s_d.dma_abort = 1'b1;
        if (s_q.dma_st != pdf_pkg::PDF_ST_IDLE && (dma_xfer_done || dma_flush_done)) begin
            s_d.dma_done = 1'b1;
            s_d.irq_st[pdf_pkg::IRQ_SCSI_DONE] = 1'b1;
        end
        if (scsi_core_event) s_d.irq_st[pdf_pkg::IRQ_SCSI_CORE] = 1'b1;
        if (net_core_event) s_d.irq_st[pdf_pkg::IRQ_NET_CORE] = 1'b1;

        // Configuration cycles: select only counts with a config command
        cfg_is_cfg = cfg_cmd == pdf_pkg::CMD_CFG_READ || cfg_cmd == pdf_pkg::CMD_CFG_WRITE;
        sel_scsi = cfg_addr_phase & cfg_is_cfg & config_select_scsi;
        sel_net = cfg_addr_phase & cfg_is_cfg & config_select_net & ~config_select_scsi;
        cfg_wr = cfg_cmd == pdf_pkg::CMD_CFG_WRITE;
        s_d.claim_scsi = sel_scsi;
        s_d.claim_net = sel_net;
        s_d.cfg_rdata = 32'h0000_0000;
        if (sel_scsi) begin
            case (cfg_dword)
                pdf_pkg::CFG_DW_STATUS: s_d.cfg_rdata = pdf_cfg_status(
                    s_q.received_target_abort_flag_scsi, s_q.received_master_abort_flag_scsi);
                pdf_pkg::CFG_DW_INTLINE: s_d.cfg_rdata = {16'h0, pdf_pkg::INTPIN_SCSI, 8'h00};
                default: s_d.cfg_rdata = 32'h0000_0000;
            endcase
            if (cfg_wr && cfg_dword == pdf_pkg::CFG_DW_STATUS) begin
                if (cfg_wdata[pdf_pkg::CFG_RTA_BIT])
                    s_d.received_target_abort_flag_scsi = 1'b0;
                if (cfg_wdata[pdf_pkg::CFG_RMA_BIT])
                    s_d.received_master_abort_flag_scsi = 1'b0;
            end
        end
        if (sel_net) begin
            case (cfg_dword)
                pdf_pkg::CFG_DW_STATUS: s_d.cfg_rdata = pdf_cfg_status(
                    s_q.received_target_abort_flag_net, s_q.received_master_abort_flag_net);
                pdf_pkg::CFG_DW_INTLINE: s_d.cfg_rdata = {16'h0, s_q.intpin_net, 8'h00};
                default: s_d.cfg_rdata = 32'h0000_0000;
            endcase
            if (cfg_wr && cfg_dword == pdf_pkg::CFG_DW_STATUS) begin
                if (cfg_wdata[pdf_pkg::CFG_RTA_BIT])
                    s_d.received_target_abort_flag_net = 1'b0;
                if (cfg_wdata[pdf_pkg::CFG_RMA_BIT])
                    s_d.received_master_abort_flag_net = 1'b0;
            end
        end
        if (target_abort_scsi) s_d.received_target_abort_flag_scsi = 1'b1;
        if (target_abort_net) s_d.received_target_abort_flag_net = 1'b1;
        if (master_abort_scsi) s_d.received_master_abort_flag_scsi = 1'b1;
        if (master_abort_net) s_d.received_master_abort_flag_net = 1'b1;

        // Parking: granted while not asking, so keep the bus from floating
        s_d.park = pci_bus_idle & bus_grant_scsi & ~bus_request_scsi;
        s_d.req_net = net_master_need;
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.dma_st <= pdf_pkg::PDF_ST_IDLE;
            s_q.irq_mask <= pdf_pkg::IRQ_MASK_RST;
            s_q.intpin_net <= pdf_pkg::INTPIN_NET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
    assign avs_readdata = s_q.rdata;
    assign cfg_claim_scsi = s_q.claim_scsi;
    assign cfg_claim_net = s_q.claim_net;
    assign cfg_rdata = s_q.cfg_rdata;
    assign dma_running = s_q.dma_st != pdf_pkg::PDF_ST_IDLE;
    assign dma_flush_command = s_q.dma_st == pdf_pkg::PDF_ST_FLUSH;
    assign bus_request_scsi = s_q.dma_st != pdf_pkg::PDF_ST_IDLE;
    assign bus_request_net = s_q.req_net;
    assign scsi_bus_owned = bus_grant_scsi & bus_request_scsi;
    assign net_bus_owned = bus_grant_net & bus_request_net;
    // Parked value is all zero, so even parity is zero as well
    assign pci_ad_o = 32'h0000_0000;
    assign pci_cbe_o = 4'h0;
    assign pci_par_o = 1'b0;
    assign pci_ad_oe = s_q.park;
    assign pci_cbe_oe = s_q.park;
    assign pci_par_oe = s_q.park;
    assign irq_out_scsi = |(s_q.irq_st[1:0] & s_q.irq_mask[1:0]);
    assign irq_out_net = s_q.irq_st[pdf_pkg::IRQ_NET_CORE]
                         & s_q.irq_mask[pdf_pkg::IRQ_NET_CORE];

endmodule : pdf_glue

// ===== hdl/pdf_pkg.sv
// Notes on behaviour
// - Two config spaces; first select reaches SCSI space, second reaches network space.
// - A config select counts only on config-cycle commands in the address phase.
// - Idle bus, SCSI granted but not requesting: drive AD, C/BE and PAR.
// - SCSI DMA target abort sets DMA status abort bit 2, no SCSI interrupt.
// - Target abort sets status bit 12 in that function's config space.
// - SCSI DMA master abort sets DMA status abort bit 2, no SCSI interrupt.
// - Master abort sets status bit 13 in that function's config space.
// - Two-bit DMA command: idle, flush, start, abort.
// - Idle command returns DMA to idle, stops transfer, keeps status, no interrupt.
// - Network function interrupt pin field resets to 02h.
// - Separate request/grant pair per function; SCSI first, network second.
// - SCSI interrupts on first output, network interrupts on second.
package pdf_pkg;

    // ==========================================================
    // Register bus offsets (byte addresses)
    localparam logic [7:0] OFS_DMA_CMD    = 8'h40;
    localparam logic [7:0] OFS_DMA_STATUS = 8'h54;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h58;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h5C;

    // ==========================================================
    // Field positions
    localparam int DST_RUN_BIT   = 0;
    localparam int DST_FLUSH_BIT = 1;
    localparam int DST_ABORT_BIT = 2;
    localparam int DST_DONE_BIT  = 3;
    localparam int IRQ_SCSI_CORE = 0;
    localparam int IRQ_SCSI_DONE = 1;
    localparam int IRQ_NET_CORE  = 2;
    localparam int CFG_RTA_BIT   = 28;
    localparam int CFG_RMA_BIT   = 29;

    // ==========================================================
    // Configuration space
    localparam logic [5:0]  CFG_DW_STATUS  = 6'h01;
    localparam logic [5:0]  CFG_DW_INTLINE = 6'h0F;
    localparam logic [3:0]  CMD_CFG_READ   = 4'hA;
    localparam logic [3:0]  CMD_CFG_WRITE  = 4'hB;
    localparam logic [7:0]  INTPIN_SCSI    = 8'h01;
    localparam logic [7:0]  INTPIN_NET     = 8'h02;
    localparam logic [2:0]  IRQ_MASK_RST   = 3'h7;

    // ==========================================================
    // DMA commands and states
    typedef enum logic [1:0] {
        PDF_CMD_IDLE  = 2'h0,
        PDF_CMD_FLUSH = 2'h1,
        PDF_CMD_START = 2'h2,
        PDF_CMD_ABORT = 2'h3
    } pdf_dma_cmd_t;

    typedef enum logic [2:0] {
        PDF_ST_IDLE  = 3'b001,
        PDF_ST_RUN   = 3'b010,
        PDF_ST_FLUSH = 3'b100
    } pdf_dma_st_t;

endpackage : pdf_pkg

// ===== testbench/pdf_far_model.sv
`timescale 1ns/10ps
module pdf_far_model (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // Requests, and a stall that holds grants back
    input  wire logic slow,
    input  wire logic bus_request_scsi,
    input  wire logic bus_request_net,
    // Arbiter answers
    output logic      pci_bus_idle,
    output logic      bus_grant_scsi,
    output logic      bus_grant_net
);
    // Parks on the SCSI pair when nobody asks, so parking gets exercised
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pci_bus_idle   <= 1'b0;
            bus_grant_scsi <= 1'b0;
            bus_grant_net  <= 1'b0;
        end else begin
            pci_bus_idle   <= !bus_request_scsi && !bus_request_net;
            bus_grant_scsi <= !slow && (bus_request_scsi || !bus_request_net);
            bus_grant_net  <= !slow && bus_request_net && !bus_request_scsi;
        end
    end
endmodule : pdf_far_model

// ===== testbench/pdf_glue_asserts.sv
`timescale 1ns/10ps
module pdf_glue_asserts (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_b,
    // Register bus
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    // Configuration
    input wire logic        cfg_addr_phase,
    input wire logic [3:0]  cfg_cmd,
    input wire logic        config_select_scsi,
    input wire logic        config_select_net,
    input wire logic        cfg_claim_scsi,
    input wire logic        cfg_claim_net,
    // Arbitration and parking
    input wire logic        pci_bus_idle,
    input wire logic        bus_grant_scsi,
    input wire logic        net_master_need,
    input wire logic        bus_request_scsi,
    input wire logic        bus_request_net,
    input wire logic        pci_ad_oe,
    input wire logic        pci_cbe_oe,
    input wire logic        pci_par_oe,
    // DMA
    input wire logic        target_abort_scsi,
    input wire logic        master_abort_scsi,
    input wire logic        dma_running,
    input wire logic        dma_flush_command
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ==========================================
    // Properties
    property p_park;
        pci_bus_idle && bus_grant_scsi && !bus_request_scsi |=> pci_ad_oe && pci_cbe_oe && pci_par_oe;
    endproperty
    property p_claim_s;
        cfg_addr_phase && config_select_scsi && cfg_cmd inside {4'hA, 4'hB} |=> cfg_claim_scsi;
    endproperty
    property p_claim_n;
        cfg_addr_phase && config_select_net && !config_select_scsi && cfg_cmd inside {4'hA, 4'hB}
            |=> cfg_claim_net;
    endproperty
    property p_cmd;
        cfg_addr_phase && !(cfg_cmd inside {4'hA, 4'hB}) |=> !cfg_claim_scsi && !cfg_claim_net;
    endproperty
    property p_unsel;
        !cfg_addr_phase || !config_select_net |=> !cfg_claim_net;
    endproperty
    property p_abort;
        target_abort_scsi || master_abort_scsi |=> !dma_running;
    endproperty
    property p_idle;
        avs_write && avs_waitrequest && avs_address == pdf_pkg::OFS_DMA_CMD
            && avs_writedata[1:0] == 2'h0 |=> !dma_running && !dma_flush_command;
    endproperty
    property p_flush;
        avs_write && avs_waitrequest && avs_address == pdf_pkg::OFS_DMA_CMD
            && avs_writedata[1:0] == 2'h1 && dma_running |=> dma_flush_command;
    endproperty
    property p_req_n;
        net_master_need |=> bus_request_net;
    endproperty
    property p_req_s;
        dma_running |-> bus_request_scsi;
    endproperty
    property p_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_park : assert property (p_park) else $error("no parking drive");
    a_claim_s : assert property (p_claim_s) else $error("scsi claim missing");
    a_claim_n : assert property (p_claim_n) else $error("net claim missing");
    a_cmd : assert property (p_cmd) else $error("claim on non-config command");
    a_unsel : assert property (p_unsel) else $error("net claim without select");
    a_abort : assert property (p_abort) else $error("abort left dma running");
    a_idle : assert property (p_idle) else $error("idle command kept dma busy");
    a_flush : assert property (p_flush) else $error("flush command not entered");
    a_req_n : assert property (p_req_n) else $error("net request missing");
    a_req_s : assert property (p_req_s) else $error("scsi request missing");
    a_wait : assert property (p_wait) else $error("more than one wait state");
    c_claim_net : cover property (cfg_claim_net);
    c_park : cover property (pci_ad_oe);
    c_flush : cover property (dma_flush_command);
endmodule : pdf_glue_asserts

// ===== testbench/pdf_glue_bench.sv
`timescale 1ns/10ps
module pdf_glue_bench;
    logic        mclk, rst_b, avs_read, avs_write, avs_waitrequest, cfg_addr_phase;
    logic        config_select_scsi, config_select_net, cfg_claim_scsi, cfg_claim_net;
    logic        pci_bus_idle, bus_grant_scsi, bus_grant_net, net_master_need, slow;
    logic        bus_request_scsi, bus_request_net, net_bus_owned, pci_ad_oe, scsi_bus_owned;
    logic        dma_running, dma_flush_command, irq_out_scsi, irq_out_net;
    logic [7:0]  avs_address, ev;
    logic [3:0]  cfg_cmd;
    logic [5:0]  cfg_dword;
    logic [31:0] avs_writedata, avs_readdata, cfg_wdata, cfg_rdata, q;
    int          n_errors, n_tests;

    pdf_glue u_dut (.mclk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_byteenable(4'hF),
        .avs_writedata, .avs_readdata, .avs_waitrequest, .cfg_addr_phase, .cfg_cmd, .cfg_dword,
        .cfg_wdata, .config_select_scsi, .config_select_net, .cfg_claim_scsi, .cfg_claim_net,
        .cfg_rdata, .pci_bus_idle, .bus_grant_scsi, .bus_grant_net, .net_master_need,
        .bus_request_scsi, .bus_request_net, .scsi_bus_owned, .net_bus_owned, .pci_ad_o(),
        .pci_ad_oe, .pci_cbe_o(), .pci_cbe_oe(), .pci_par_o(), .pci_par_oe(),
        .target_abort_scsi(ev[0]), .master_abort_scsi(ev[1]), .target_abort_net(ev[2]),
        .master_abort_net(ev[3]), .dma_xfer_done(ev[4]), .dma_flush_done(ev[5]),
        .scsi_core_event(ev[6]), .net_core_event(ev[7]), .dma_running, .dma_flush_command,
        .irq_out_scsi, .irq_out_net);
    pdf_far_model u_arb (.mclk, .rst_b, .slow, .bus_request_scsi, .bus_request_net,
        .pci_bus_idle, .bus_grant_scsi, .bus_grant_net);

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // ==========================================
    // Tasks
    task results;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Single word per access; the slave decides when it answers
    // Waitrequest and read data are taken at the rising edge, before it updates them
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) n_errors++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : acc
    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        acc(1'b0, a, 32'h0000_0000);
        chk(q & m, e);
    endtask : rdc
    task cfgc(input logic [1:0] s, input logic [3:0] c, input logic [5:0] dw,
              input logic [31:0] d, input logic [1:0] ecl, input logic [31:0] m,
              input logic [31:0] e);
        @(posedge mclk);
        cfg_addr_phase <= 1'b1;
        {config_select_net, config_select_scsi} <= s;
        cfg_cmd   <= c;
        cfg_dword <= dw;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_addr_phase <= 1'b0;
        @(negedge mclk);
        chk(32'({cfg_claim_net, cfg_claim_scsi}), 32'(ecl));
        chk(cfg_rdata & m, e);
    endtask : cfgc
    task pulse(input logic [7:0] m);
        @(posedge mclk);
        ev <= m;
        @(posedge mclk);
        ev <= 8'h00;
    endtask : pulse
    // ==========================================
    // Sequence
    initial begin
        {avs_read, avs_write, cfg_addr_phase, config_select_scsi, config_select_net} = '0;
        {net_master_need, slow, avs_address, ev, cfg_cmd, cfg_dword} = '0;
        {avs_writedata, cfg_wdata} = '0;
        {n_errors, n_tests} = '0;
        rst_b = 1'b0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        rdc(8'h5C, 32'h0000_0007, 32'h0000_0007);
        rdc(8'h54, 32'h0000_000F, 32'h0000_0000);
        rdc(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
        cfgc(2'b10, 4'hA, 6'h0F, 0, 2'b10, 32'h0000_FF00, 32'h0000_0200);
        cfgc(2'b01, 4'hA, 6'h0F, 0, 2'b01, 32'h0000_FF00, 32'h0000_0100);
        cfgc(2'b11, 4'h6, 6'h0F, 0, 2'b00, 32'hFFFF_FFFF, 0);
        cfgc(2'b00, 4'hB, 6'h0F, 0, 2'b00, 32'hFFFF_FFFF, 0);
        chk(32'(pci_ad_oe), 1);
        acc(1'b1, 8'h40, 2);
        rdc(8'h54, 32'h0000_0007, 32'h0000_0001);
        chk(32'({bus_request_scsi, pci_ad_oe, scsi_bus_owned}), 5);
        acc(1'b1, 8'h40, 1);
        rdc(8'h54, 32'h0000_0007, 32'h0000_0002);
        pulse(8'h20);
        rdc(8'h54, 32'h0000_0007, 32'h0000_0000);
        // Flush completion raised the done interrupt; clear it so aborts start clean
        acc(1'b1, 8'h58, 32'h0000_0007);
        acc(1'b1, 8'h40, 2);
        pulse(8'h01);
        rdc(8'h54, 32'h0000_0007, 32'h0000_0004);
        chk(32'(irq_out_scsi), 0);
        cfgc(2'b01, 4'hA, 6'h01, 0, 2'b01, 32'h3000_0000, 32'h1000_0000);
        acc(1'b1, 8'h54, 32'h0000_000C);
        acc(1'b1, 8'h40, 2);
        pulse(8'h02);
        rdc(8'h54, 32'h0000_0007, 32'h0000_0004);
        chk(32'(irq_out_scsi), 0);
        cfgc(2'b01, 4'hA, 6'h01, 0, 2'b01, 32'h3000_0000, 32'h3000_0000);
        acc(1'b1, 8'h54, 4);
        acc(1'b1, 8'h40, 2);
        acc(1'b1, 8'h40, 0);
        rdc(8'h54, 32'h0000_000F, 32'h0000_0000);
        rdc(8'h58, 32'h0000_0007, 32'h0000_0000);
        acc(1'b1, 8'h40, 2);
        acc(1'b1, 8'h40, 3);
        rdc(8'h54, 32'h0000_0007, 32'h0000_0004);
        pulse(8'h0C);
        cfgc(2'b10, 4'hA, 6'h01, 0, 2'b10, 32'h3000_0000, 32'h3000_0000);
        chk(32'(irq_out_net), 0);
        cfgc(2'b10, 4'hB, 6'h01, 32'h3000_0000, 2'b10, 0, 0);
        cfgc(2'b10, 4'hA, 6'h01, 0, 2'b10, 32'h3000_0000, 0);
        pulse(8'h40);
        rdc(8'h58, 32'h0000_0007, 32'h0000_0001);
        chk(32'({irq_out_scsi, irq_out_net}), 2);
        pulse(8'h80);
        acc(1'b1, 8'h5C, 0);
        rdc(8'h58, 32'h0000_0007, 32'h0000_0005);
        chk(32'({irq_out_scsi, irq_out_net}), 0);
        acc(1'b1, 8'h5C, 4);
        rdc(8'h58, 32'h0000_0007, 32'h0000_0005);
        chk(32'({irq_out_scsi, irq_out_net}), 1);
        acc(1'b1, 8'h58, 7);
        rdc(8'h58, 32'h0000_0007, 32'h0000_0000);
        // Arbiter stalls first, so the net pair must wait for its own grant
        @(posedge mclk);
        slow            <= 1'b1;
        net_master_need <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(32'({bus_request_net, net_bus_owned}), 2);
        slow <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(32'(net_bus_owned), 1);
        results();
    end
    initial begin
        #200_000;
        n_errors++;
        results();
    end
endmodule : pdf_glue_bench

bind pdf_glue pdf_glue_asserts u_chk (.mclk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_waitrequest, .cfg_addr_phase, .cfg_cmd, .config_select_scsi,
    .config_select_net, .cfg_claim_scsi, .cfg_claim_net, .pci_bus_idle, .bus_grant_scsi,
    .net_master_need, .bus_request_scsi, .bus_request_net, .pci_ad_oe, .pci_cbe_oe,
    .pci_par_oe, .target_abort_scsi, .master_abort_scsi, .dma_running, .dma_flush_command);
